// ===== core/acr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"
// What this block does
// - Scan and repeat bits pick one of four normal modes.
// - Fixed single mode flags done and irq and drops busy in the same cycle.
// - Fixed repeat at timing 00 flags done after each conversion.
// - Fixed repeat at timing 01 flags done after every fourth.
// - Fixed repeat at timing 10 flags done after every eighth.
// - Scan single flags done after the whole scan and drops busy.
// - Scan repeat flags done per pass with busy held high.
// - Repeat modes keep busy high; single modes drop it.
// - A priority completion pulses its irq, sets its flag, drops busy.
// - Reading a done flag clears it.
// - Outside fixed repeat, input n lands in slot n mod 8.
// - Fixed repeat fills slot 0, slots 0-3 or slots 0-7 cyclically.
// - Priority results go to the priority register only.
// - A priority conversion suspends and then resumes normal work.
// - Clearing repeat stops after the current conversion.
module acr_top #(
    parameter int WIDTH = 12
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic NORMAL_START,
    input wire logic MODE_SCAN,
    input wire logic MODE_REPEAT,
    input wire logic [1:0] MODE_ITM,
    input wire logic PRIO_START,
    input wire logic CONV_DONE,
    input wire logic [3:0] CONV_CHANNEL,
    input wire logic CONV_LAST_IN_SCAN,
    input wire logic [WIDTH-1:0] CONV_DATA,
    input wire logic NORMAL_DONE_READ,
    input wire logic PRIO_DONE_READ,
    input wire logic [2:0] SLOT_SEL,
    output logic [WIDTH-1:0] SLOT_DATA,
    output logic [WIDTH-1:0] PRIORITY_RESULT_REG,
    output logic NORMAL_BUSY,
    output logic PRIORITY_BUSY,
    output logic NORMAL_DONE_FLAG,
    output logic PRIORITY_DONE_FLAG,
    output logic NORMAL_DONE_IRQ,
    output logic PRIORITY_DONE_IRQ,
    output logic NORMAL_SUSPENDED
);
    typedef struct packed {
        acr_pkg::acr_state_e st;
        logic n_busy;
        logic p_busy;
        logic n_done;
        logic p_done;
        logic n_irq;
        logic p_irq;
        logic rpt_run;
        logic susp;
        logic [2:0] rpt_slot;
        logic [WIDTH-1:0] prio_res;
    } acr_state_s;

    acr_state_s st_ff;
    acr_state_s nxt_st;
    logic [1:0] mode;
    logic [2:0] last_slot;
    logic wr_en;
    logic [2:0] wr_slot;

    // =========================================================
    // mode decode
    // mode from bits
    assign mode = {MODE_SCAN, MODE_REPEAT};
    always_comb begin
        unique case (MODE_ITM)
            `ACR_ITM_EVERY4: last_slot = `ACR_LAST_SLOT4;
            `ACR_ITM_EVERY8: last_slot = `ACR_LAST_SLOT8;
            default: last_slot = `ACR_LAST_SLOT1;
        endcase
    end

    // =========================================================
    // result routing into the slot memory
    // repeat slot pointer
    assign wr_slot = (mode == `ACR_MODE_FIX_REPEAT) ? st_ff.rpt_slot
                                                   : CONV_CHANNEL[2:0];
    // a result cut off by a priority start is dropped, core redoes it
    assign wr_en = CONV_DONE && !PRIO_START
                   && st_ff.st == acr_pkg::ACR_NORMAL;

    acr_slot_mem #(.WIDTH(WIDTH)) u_mem (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .wr_en(wr_en),
        .wr_slot(wr_slot),
        .wr_data(CONV_DATA),
        .rd_slot(SLOT_SEL),
        .rd_data(SLOT_DATA)
    );

    // =========================================================
    // sequencing, flags and pulses
    always_comb begin
        nxt_st = st_ff;
        nxt_st.n_irq = 1'b0;
        nxt_st.p_irq = 1'b0;
        // clear on read; a same-cycle set wins below
        if (NORMAL_DONE_READ) begin
            nxt_st.n_done = 1'b0;
        end
        if (PRIO_DONE_READ) begin
            nxt_st.p_done = 1'b0;
        end
        unique case (st_ff.st)
            acr_pkg::ACR_IDLE: begin
                if (PRIO_START) begin
                    nxt_st.st = acr_pkg::ACR_PRIO;
                    nxt_st.p_busy = 1'b1;
                end else if (NORMAL_START) begin
                    nxt_st.st = acr_pkg::ACR_NORMAL;
                    nxt_st.n_busy = 1'b1;
                    nxt_st.rpt_slot = `ACR_SLOT_ZERO;
                    nxt_st.rpt_run = MODE_REPEAT;
                end
            end
            acr_pkg::ACR_NORMAL: begin
                if (PRIO_START) begin
                    nxt_st.st = acr_pkg::ACR_PRIO;
                    nxt_st.p_busy = 1'b1;
                end else if (CONV_DONE) begin
                    unique case (mode)
                        `ACR_MODE_FIX_SINGLE: begin
                            nxt_st.n_done = 1'b1;
                            nxt_st.n_irq = 1'b1;
                            nxt_st.n_busy = 1'b0;
                            nxt_st.st = acr_pkg::ACR_IDLE;
                        end
                        `ACR_MODE_FIX_REPEAT: begin
                            if (st_ff.rpt_slot == last_slot) begin
                                nxt_st.n_done = 1'b1;
                                nxt_st.n_irq = 1'b1;
                                nxt_st.rpt_slot = `ACR_SLOT_ZERO;
                            end else begin
                                nxt_st.rpt_slot = st_ff.rpt_slot + 3'h1;
                            end
                        end
                        `ACR_MODE_SCAN_SINGLE: begin
                            if (CONV_LAST_IN_SCAN) begin
                                nxt_st.n_done = 1'b1;
                                nxt_st.n_irq = 1'b1;
                                nxt_st.n_busy = 1'b0;
                                nxt_st.st = acr_pkg::ACR_IDLE;
                            end
                        end
                        `ACR_MODE_SCAN_REPEAT: begin
                            if (CONV_LAST_IN_SCAN) begin
                                nxt_st.n_done = 1'b1;
                                nxt_st.n_irq = 1'b1;
                            end
                        end
                    endcase
                    // repeat cleared: stop after this one
                    // only a started repeat run stops here, so a scan
                    // single keeps going until its last channel
                    if (st_ff.rpt_run && !MODE_REPEAT) begin
                        nxt_st.n_busy = 1'b0;
                        nxt_st.st = acr_pkg::ACR_IDLE;
                    end
                end
            end
            acr_pkg::ACR_PRIO: begin
                if (CONV_DONE) begin
                    nxt_st.prio_res = CONV_DATA;
                    nxt_st.p_done = 1'b1;
                    nxt_st.p_irq = 1'b1;
                    nxt_st.p_busy = 1'b0;
                    nxt_st.st = st_ff.n_busy ? acr_pkg::ACR_NORMAL
                                             : acr_pkg::ACR_IDLE;
                end
            end
            default: nxt_st.st = acr_pkg::ACR_IDLE;
        endcase
        // suspended level kept in a flop
        nxt_st.susp = nxt_st.st == acr_pkg::ACR_PRIO && nxt_st.n_busy;
    end

    // =========================================================
    // state register
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state flops
    assign NORMAL_BUSY = st_ff.n_busy;
    assign PRIORITY_BUSY = st_ff.p_busy;
    assign NORMAL_DONE_FLAG = st_ff.n_done;
    assign PRIORITY_DONE_FLAG = st_ff.p_done;
    assign NORMAL_DONE_IRQ = st_ff.n_irq;
    assign PRIORITY_DONE_IRQ = st_ff.p_irq;
    assign PRIORITY_RESULT_REG = st_ff.prio_res;
    assign NORMAL_SUSPENDED = st_ff.susp;

    // =========================================================
    // checks
    // single busy drop
    property p_single;
        @(posedge CLOCK) disable iff (!RST_N)
        (st_ff.st == acr_pkg::ACR_NORMAL && !PRIO_START && CONV_DONE
         && mode == `ACR_MODE_FIX_SINGLE)
        |=> NORMAL_DONE_IRQ && NORMAL_DONE_FLAG && !NORMAL_BUSY;
    endproperty
    single_done_a: assert property (p_single)
        else $error("fixed single completion wrong");
    scan_rpt_busy_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (NORMAL_DONE_IRQ && MODE_REPEAT && $past(MODE_REPEAT))
        |-> NORMAL_BUSY)
        else $error("busy dropped in repeat mode");
    prio_done_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_ff.st == acr_pkg::ACR_PRIO && CONV_DONE)
        |=> PRIORITY_DONE_IRQ && PRIORITY_DONE_FLAG && !PRIORITY_BUSY
            && PRIORITY_RESULT_REG == $past(CONV_DATA))
        else $error("priority completion wrong");
    read_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (NORMAL_DONE_READ && !NORMAL_DONE_IRQ) ##1 !NORMAL_DONE_IRQ
        |-> !NORMAL_DONE_FLAG)
        else $error("done flag not cleared on read");
    every4_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (wr_en && mode == `ACR_MODE_FIX_REPEAT
         && MODE_ITM == `ACR_ITM_EVERY4
         && st_ff.rpt_slot != `ACR_LAST_SLOT4)
        |=> !NORMAL_DONE_IRQ)
        else $error("early interrupt in every-four setting");
    slot_bound_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (mode == `ACR_MODE_FIX_REPEAT && MODE_ITM == `ACR_ITM_EVERY1 && wr_en)
        |-> wr_slot == `ACR_SLOT_ZERO)
        else $error("every-one setting left slot 0");
    resume_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_ff.st == acr_pkg::ACR_PRIO && CONV_DONE && st_ff.n_busy)
        |=> st_ff.st == acr_pkg::ACR_NORMAL && NORMAL_BUSY)
        else $error("normal work not resumed");
    stop_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (wr_en && st_ff.rpt_run && !MODE_REPEAT) |=> !NORMAL_BUSY)
        else $error("busy held after repeat cleared");
    prio_cov: cover property (@(posedge CLOCK) NORMAL_SUSPENDED);
    rpt8_cov: cover property (@(posedge CLOCK)
        NORMAL_DONE_IRQ && MODE_ITM == `ACR_ITM_EVERY8);
    scan_cov: cover property (@(posedge CLOCK)
        NORMAL_DONE_IRQ && mode == `ACR_MODE_SCAN_SINGLE);
endmodule : acr_top
`default_nettype wire

// ===== core/acr_cfg.svh
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// normal mode bit encodings {scan, repeat}
`define ACR_MODE_FIX_SINGLE 2'h0
`define ACR_MODE_FIX_REPEAT 2'h1
`define ACR_MODE_SCAN_SINGLE 2'h2
`define ACR_MODE_SCAN_REPEAT 2'h3
// interrupt-timing field encodings
`define ACR_ITM_EVERY1 2'h0
`define ACR_ITM_EVERY4 2'h1
`define ACR_ITM_EVERY8 2'h2
// last slot index per interrupt-timing setting
`define ACR_LAST_SLOT1 3'h0
`define ACR_LAST_SLOT4 3'h3
`define ACR_LAST_SLOT8 3'h7
`define ACR_SLOT_ZERO 3'h0
`endif

// ===== core/acr_pkg.sv
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_NORMAL,
        ACR_PRIO
    } acr_state_e;
endpackage : acr_pkg

// ===== core/acr_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
// eight result slots; read data registered
module acr_slot_mem #(
    parameter int WIDTH = 12
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic wr_en,
    input wire logic [2:0] wr_slot,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [2:0] rd_slot,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [8];
    // =========================================================
    // storage and registered read
    always_ff @(posedge CLOCK) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_data;
        end
        if (!RST_N) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_slot];
        end
    end
endmodule : acr_slot_mem
`default_nettype wire

// ===== test/acr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"
module acr_top_bench;
    localparam int W = 12;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic normal_start = 1'b0;
    logic mode_scan = 1'b0;
    logic mode_repeat = 1'b0;
    logic [1:0] mode_itm = 2'h0;
    logic prio_start = 1'b0;
    logic conv_done = 1'b0;
    logic [3:0] conv_channel = 4'h0;
    logic conv_last = 1'b0;
    logic [W-1:0] conv_data = 12'h000;
    logic normal_read = 1'b0;
    logic prio_read = 1'b0;
    logic [2:0] slot_sel = 3'h0;
    logic [W-1:0] slot_data, prio_result;
    logic normal_busy, prio_busy, normal_flag, prio_flag;
    logic normal_irq, prio_irq, suspended;
    int fail_count = 0;
    int total_checks = 0;

    acr_top #(.WIDTH(W)) u_acr_top (.CLOCK(clock), .RST_N(rst_n),
        .NORMAL_START(normal_start), .MODE_SCAN(mode_scan),
        .MODE_REPEAT(mode_repeat), .MODE_ITM(mode_itm),
        .PRIO_START(prio_start), .CONV_DONE(conv_done),
        .CONV_CHANNEL(conv_channel), .CONV_LAST_IN_SCAN(conv_last),
        .CONV_DATA(conv_data), .NORMAL_DONE_READ(normal_read),
        .PRIO_DONE_READ(prio_read), .SLOT_SEL(slot_sel),
        .SLOT_DATA(slot_data), .PRIORITY_RESULT_REG(prio_result),
        .NORMAL_BUSY(normal_busy), .PRIORITY_BUSY(prio_busy),
        .NORMAL_DONE_FLAG(normal_flag), .PRIORITY_DONE_FLAG(prio_flag),
        .NORMAL_DONE_IRQ(normal_irq), .PRIORITY_DONE_IRQ(prio_irq),
        .NORMAL_SUSPENDED(suspended));

    // ==================================================
    // clock and helpers
    initial forever #2.5 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // inputs move on falling edges only, so no race with the design
    task automatic start(input logic [1:0] mode, input logic [1:0] itm);
        mode_scan = mode[1];
        mode_repeat = mode[0];
        mode_itm = itm;
        normal_start = 1'b1;
        @(negedge clock);
        normal_start = 1'b0;
    endtask : start

    // one conversion pulse; outputs are settled when this returns
    // an idle cycle first, so back-to-back calls never glitch the strobe
    task automatic conv(input logic [3:0] ch, input logic last,
                        input logic [W-1:0] d);
        @(negedge clock);
        conv_done = 1'b1;
        conv_channel = ch;
        conv_last = last;
        conv_data = d;
        @(negedge clock);
        conv_done = 1'b0;
        conv_last = 1'b0;
    endtask : conv

    task automatic read_slot(input logic [2:0] s, input logic [W-1:0] exp);
        slot_sel = s;
        @(negedge clock);
        chk(slot_data, exp, "slot content");
    endtask : read_slot

    task automatic read_flags;
        normal_read = 1'b1;
        prio_read = 1'b1;
        @(negedge clock);
        normal_read = 1'b0;
        prio_read = 1'b0;
        @(negedge clock);
        chk({normal_flag, prio_flag}, 2'h0, "flags after read");
    endtask : read_flags

    task automatic tally_and_finish;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ==================================================
    // watchdog: tests need under 150 cycles
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        tally_and_finish();
    end

    // ==================================================
    // test sequence
    initial begin
        int n;
        repeat (12) @(negedge clock);
        chk({normal_busy, prio_busy, normal_flag, prio_flag, normal_irq,
             prio_irq, suspended}, 16'h0, "reset outputs");
        rst_n = 1'b1;
        // fixed single, channel 13 lands in slot 5
        start(`ACR_MODE_FIX_SINGLE, `ACR_ITM_EVERY1);
        chk(normal_busy, 1'b1, "busy on start");
        conv(4'hD, 1'b0, 12'hA5C);
        chk({normal_irq, normal_flag, normal_busy}, 3'h6, "single");
        @(negedge clock);
        chk({normal_irq, normal_busy}, 2'h0, "irq one cycle");
        read_slot(3'h5, 12'hA5C);
        read_flags();
        // fixed repeat at every one, four and eight conversions
        for (int m = 0; m < 3; m++) begin
            n = (m == 0) ? 1 : (m == 1) ? 4 : 8;
            start(`ACR_MODE_FIX_REPEAT, 2'(m));
            for (int k = 0; k < 2 * n; k++) begin
                conv(4'h2, 1'b0, 12'(16'h100 + k));
                chk(normal_irq, ((k + 1) % n) == 0, "irq");
                chk(normal_flag, k >= n - 1, "flag");
                chk(normal_busy, 1'b1, "repeat busy");
            end
            for (int s = 0; s < n; s++) begin
                read_slot(3'(s), 12'(16'h100 + n + s));
            end
            mode_repeat = 1'b0;
            conv(4'h2, 1'b0, 12'h0EE);
            chk(normal_busy, 1'b0, "stop repeat");
            read_flags();
        end
        // scan single over channels 9 to 11
        start(`ACR_MODE_SCAN_SINGLE, `ACR_ITM_EVERY1);
        conv(4'h9, 1'b0, 12'h291);
        conv(4'hA, 1'b0, 12'h2A2);
        chk(normal_irq, 1'b0, "no irq mid scan");
        conv(4'hB, 1'b1, 12'h2B3);
        chk({normal_irq, normal_flag, normal_busy}, 3'h6, "scan");
        read_slot(3'h1, 12'h291);
        read_slot(3'h3, 12'h2B3);
        read_flags();
        // scan repeat over channels 12 and 13
        start(`ACR_MODE_SCAN_REPEAT, `ACR_ITM_EVERY1);
        conv(4'hC, 1'b0, 12'h3C4);
        conv(4'hD, 1'b1, 12'h3D5);
        chk({normal_irq, normal_flag, normal_busy}, 3'h7, "pass");
        mode_repeat = 1'b0;
        conv(4'hC, 1'b0, 12'h3C6);
        chk(normal_busy, 1'b0, "scan stop");
        read_slot(3'h5, 12'h3D5);
        read_flags();
        // priority conversion cutting into fixed repeat
        start(`ACR_MODE_FIX_REPEAT, `ACR_ITM_EVERY1);
        conv(4'h2, 1'b0, 12'h111);
        prio_start = 1'b1;
        @(negedge clock);
        prio_start = 1'b0;
        chk({prio_busy, suspended, normal_busy}, 3'h7, "suspend");
        conv(4'h3, 1'b0, 12'hBEE);
        chk({prio_irq, prio_flag, prio_busy}, 3'h6, "prio done");
        chk(prio_result, 12'hBEE, "prio result");
        chk({normal_irq, normal_busy, suspended}, 3'h2, "resume");
        read_slot(3'h0, 12'h111);
        read_slot(3'h3, 12'h2B3);
        conv(4'h2, 1'b0, 12'h222);
        chk(normal_irq, 1'b1, "normal after prio");
        read_slot(3'h0, 12'h222);
        read_flags();
        mode_repeat = 1'b0;
        conv(4'h2, 1'b0, 12'h333);
        chk(normal_busy, 1'b0, "final stop");
        tally_and_finish();
    end
endmodule : acr_top_bench
`default_nettype wire
